// ==== src/fsp_core.sv ====
`timescale 1ns/1ns
`include "fsp_params.svh"
module fsp_core #(
    parameter logic [23:0] ID_CODE = 24'h00_5A5A,
    parameter logic [79:0] PART_NAME = 80'h4445_5649_4345_2020_2020,
    parameter logic [19:0] LAST_ADDR = 20'h0_1FFF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire fsp_pkg::fsp_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic [19:0] cmd_addr,
    input wire logic [2:0] cmd_prot,
    input wire logic self_valid,
    input wire logic self_is_write,
    input wire logic [19:0] self_addr,
    input wire logic code_blank,
    input wire logic [2:0] nv_prot,
    input wire logic [7:0] fw_major,
    input wire logic [7:0] fw_minor,
    input wire logic [7:0] fw_patch,
    output logic cmd_ready,
    output logic [7:0] resp_data,
    output logic resp_valid,
    output logic resp_last,
    output logic erase_go,
    output logic write_go,
    output logic self_go,
    output logic self_refused,
    output logic [19:0] op_addr,
    output logic nv_prot_we,
    output logic [2:0] nv_prot_wdata,
    output logic [2:0] active_prot
);
    import fsp_pkg::*;

    fsp_state_t state;
    logic [4:0] sig_idx;
    logic loaded;
    logic clear_armed;
    logic [7:0] rom_byte;

    fsp_sig_rom #(
        .ID_CODE(ID_CODE),
        .PART_NAME(PART_NAME),
        .LAST_ADDR(LAST_ADDR),
        .FW_VER(24'h00_0000)
    ) u_rom (
        .core_clk(core_clk),
        .resetn(resetn),
        .index(sig_idx),
        .rd_data(rom_byte)
    );

    wire in_boot = cmd_addr <= `FSP_BOOT_LAST;
    wire self_in_boot = self_addr <= `FSP_BOOT_LAST;
    wire erase_blocked = active_prot[`FSP_BIT_ERASE] ||
        (active_prot[`FSP_BIT_BOOT] && in_boot);
    wire write_blocked = active_prot[`FSP_BIT_WRITE] ||
        (active_prot[`FSP_BIT_BOOT] && in_boot);
    wire clear_ok = clear_armed && active_prot[`FSP_BIT_ERASE] &&
        active_prot[`FSP_BIT_BOOT] && code_blank;
    wire take = cmd_valid && cmd_ready;
    wire cmd_ok = (cmd == FSP_CMD_ERASE) ? !erase_blocked :
        (cmd == FSP_CMD_WRITE) ? !write_blocked :
        (cmd == FSP_CMD_PROT_CLEAR) ? clear_ok :
        (cmd == FSP_CMD_SIG || cmd == FSP_CMD_PROT_SET);
    wire [2:0] set_value = nv_prot | cmd_prot;
    wire [2:0] clear_value = nv_prot & ~(3'h1 << `FSP_BIT_WRITE);
    wire self_block = active_prot[`FSP_BIT_BOOT] && self_in_boot;
    // rom data lags the index by one step: byte k goes out while sig_idx is k + 1
    wire [7:0] fw_byte = (sig_idx == `FSP_SIG_ADDR_END + 5'd2) ? fw_major :
        (sig_idx == `FSP_SIG_ADDR_END + 5'd3) ? fw_minor : fw_patch;
    wire sig_rom_part = sig_idx <= `FSP_SIG_ADDR_END + 5'd1;

    assign cmd_ready = loaded && (state == FSP_IDLE);

    // protection latched once after reset: programming mode entry
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            active_prot <= `FSP_PROT_NONE;
            loaded <= 1'b0;
            clear_armed <= 1'b0;
        end else if (!loaded) begin
            active_prot <= nv_prot;
            loaded <= 1'b1;
            clear_armed <= nv_prot[`FSP_BIT_WRITE];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= FSP_IDLE;
            sig_idx <= 5'd0;
            resp_valid <= 1'b0;
            resp_last <= 1'b0;
            resp_data <= 8'h00;
        end else begin
            resp_valid <= 1'b0;
            resp_last <= 1'b0;
            unique case (state)
                FSP_IDLE: begin
                    if (take) begin
                        resp_valid <= 1'b1;
                        resp_data <= cmd_ok ? `FSP_ACK : `FSP_NAK;
                        resp_last <= !(cmd == FSP_CMD_SIG);
                        sig_idx <= 5'd0;
                        state <= (cmd == FSP_CMD_SIG) ? FSP_SIG : FSP_IDLE;
                    end
                end
                FSP_SIG: begin
                    sig_idx <= sig_idx + 5'd1;
                    state <= FSP_RESP;
                end
                FSP_RESP: begin
                    resp_valid <= 1'b1;
                    resp_data <= sig_rom_part ? rom_byte : fw_byte;
                    if (sig_idx == `FSP_SIG_LEN) begin
                        resp_last <= 1'b1;
                        state <= FSP_IDLE;
                    end else begin
                        state <= FSP_SIG;
                    end
                end
                default: state <= FSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            erase_go <= 1'b0;
            write_go <= 1'b0;
            self_go <= 1'b0;
            self_refused <= 1'b0;
            op_addr <= 20'h0_0000;
            nv_prot_we <= 1'b0;
            nv_prot_wdata <= `FSP_PROT_NONE;
        end else begin
            erase_go <= take && cmd == FSP_CMD_ERASE && !erase_blocked;
            write_go <= take && cmd == FSP_CMD_WRITE && !write_blocked;
            self_go <= self_valid && !self_block;
            self_refused <= self_valid && self_block;
            nv_prot_we <= take && ((cmd == FSP_CMD_PROT_SET) ||
                (cmd == FSP_CMD_PROT_CLEAR && clear_ok));
            if (take) begin
                op_addr <= cmd_addr;
                nv_prot_wdata <= (cmd == FSP_CMD_PROT_CLEAR) ? clear_value : set_value;
            end else if (self_valid) begin
                op_addr <= self_addr;
            end
        end
    end
endmodule

// ==== src/fsp_params.svh ====
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

`define FSP_SIG_LEN 5'd19
`define FSP_SIG_CODE_END 5'd2
`define FSP_SIG_NAME_END 5'd12
`define FSP_SIG_ADDR_END 5'd15
`define FSP_BOOT_LAST 20'h0_0FFF
`define FSP_ACK 8'h06
`define FSP_NAK 8'h15
`define FSP_PROT_NONE 3'h0
`define FSP_BIT_ERASE 0
`define FSP_BIT_WRITE 1
`define FSP_BIT_BOOT 2

`endif

// ==== src/fsp_pkg.sv ====
package fsp_pkg;
    typedef enum logic [2:0] {
        FSP_CMD_NONE,
        FSP_CMD_SIG,
        FSP_CMD_ERASE,
        FSP_CMD_WRITE,
        FSP_CMD_PROT_SET,
        FSP_CMD_PROT_CLEAR,
        FSP_CMD_OTHER
    } fsp_cmd_t;
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_SIG,
        FSP_RESP
    } fsp_state_t;
endpackage

// ==== src/fsp_sig_rom.sv ====
`timescale 1ns/1ns
`include "fsp_params.svh"
module fsp_sig_rom #(
    parameter logic [23:0] ID_CODE = 24'h00_5A5A,
    parameter logic [79:0] PART_NAME = 80'h4445_5649_4345_2020_2020,
    parameter logic [19:0] LAST_ADDR = 20'h0_1FFF,
    parameter logic [23:0] FW_VER = 24'h01_0203
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] index,
    output logic [7:0] rd_data
);
    // id code is arbitrary, not a real part code
    wire [23:0] last_addr_w = {4'h0, LAST_ADDR};
    wire [151:0] image = {ID_CODE, PART_NAME,
        last_addr_w[7:0], last_addr_w[15:8], last_addr_w[23:16], FW_VER};
    wire [7:0] sel_byte = (index < `FSP_SIG_LEN) ?
        image[151 - 8 * index -: 8] : 8'h00;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= sel_byte;
        end
    end
endmodule

// ==== sim/fsp_nv.sv ====
`timescale 1ns/1ns
module fsp_nv (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [2:0] wdata,
    output logic [2:0] bits
);
    // nonvolatile: no reset, keeps value across resets, ships cleared
    initial bits = 3'h0;
    always @(posedge core_clk) if (we) bits <= wdata;
endmodule

// ==== sim/fsp_chk_sva.sv ====
`timescale 1ns/1ns
`include "fsp_params.svh"
module fsp_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire fsp_pkg::fsp_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic [19:0] cmd_addr,
    input wire logic [2:0] cmd_prot,
    input wire logic [2:0] nv_prot,
    input wire logic cmd_ready,
    input wire logic [7:0] resp_data,
    input wire logic resp_valid,
    input wire logic resp_last,
    input wire logic erase_go,
    input wire logic write_go,
    input wire logic [19:0] op_addr,
    input wire logic nv_prot_we,
    input wire logic [2:0] nv_prot_wdata,
    input wire logic [2:0] active_prot
);
    import fsp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire take = cmd_valid && cmd_ready;
    wire boot = active_prot[2] && cmd_addr <= `FSP_BOOT_LAST;
    wire ers = take && cmd == FSP_CMD_ERASE;
    wire wrt = take && cmd == FSP_CMD_WRITE;
    a_erase_refused: assert property (ers && active_prot[0]
        |=> !erase_go && resp_data == `FSP_NAK) else $error("erase not refused");
    a_write_refused: assert property (wrt && active_prot[1]
        |=> !write_go && resp_data == `FSP_NAK) else $error("write not refused");
    a_boot_refused: assert property ((ers || wrt) && boot
        |=> !erase_go && !write_go) else $error("boot region changed");
    a_erase_allowed: assert property (ers && !active_prot[0] && !boot
        |=> erase_go && op_addr == $past(cmd_addr)) else $error("erase not run");
    a_resp_follows: assert property (take
        |=> resp_valid && resp_data inside {`FSP_ACK, `FSP_NAK}) else $error("no reply");
    a_prot_held: assert property ($past(resetn, 2)
        |-> $stable(active_prot)) else $error("protection changed in session");
    a_prot_merge: assert property (take && cmd == FSP_CMD_PROT_SET
        |=> nv_prot_we && nv_prot_wdata == ($past(nv_prot) | $past(cmd_prot)))
        else $error("bad stored protection");
    a_sig_length: assert property (take && cmd == FSP_CMD_SIG
        |=> !cmd_ready ##38 resp_last) else $error("bad reply length");
    a_clear_refused: assert property (take && cmd == FSP_CMD_PROT_CLEAR
        && !(active_prot[`FSP_BIT_ERASE] && active_prot[`FSP_BIT_BOOT])
        |=> !nv_prot_we && resp_data == `FSP_NAK) else $error("clear not refused");
endmodule
bind fsp_core fsp_chk u_chk (.*);

// ==== sim/tb.sv ====
`timescale 1ns/1ns
`include "fsp_params.svh"
module tb;
    import fsp_pkg::*;
    typedef struct packed {logic rst; fsp_cmd_t cmd; logic [19:0] addr; logic [2:0] prot;
        logic blank; logic [7:0] resp; logic e; logic w; logic [2:0] ap;} fsp_row_t;
    localparam logic [23:0] ID = 24'h5A_A55A; // arbitrary value
    localparam logic [79:0] NAME = 80'h4142_4344_4546_4748_494A;
    localparam logic [19:0] LAST = 20'h0_3FFF;
    localparam logic [151:0] SIG = {ID, NAME, LAST[7:0], LAST[15:8], 4'h0, LAST[19:16],
        24'h01_0203};
    localparam logic [7:0] A = `FSP_ACK, N = `FSP_NAK;
    localparam fsp_cmd_t E = FSP_CMD_ERASE, W = FSP_CMD_WRITE, P = FSP_CMD_PROT_SET;
    localparam fsp_cmd_t C = FSP_CMD_PROT_CLEAR;
    fsp_row_t rows [14] = '{'{0, E, 20'h0_2000, 0, 0, A, 1, 0, 0},
        '{0, P, 0, 1, 0, A, 0, 0, 0}, '{0, E, 20'h0_2000, 0, 0, A, 1, 0, 0},
        '{1, E, 20'h0_2000, 0, 0, N, 0, 0, 1}, '{0, W, 20'h0_2000, 0, 0, A, 0, 1, 1},
        '{0, C, 0, 0, 1, N, 0, 0, 1}, '{0, P, 0, 6, 0, A, 0, 0, 1},
        '{1, W, 20'h0_2000, 0, 0, N, 0, 0, 7}, '{0, C, 0, 0, 0, N, 0, 0, 7},
        '{0, C, 0, 0, 1, A, 0, 0, 7}, '{1, W, 20'h0_0FFF, 0, 0, N, 0, 0, 5},
        '{0, W, 20'h0_1000, 0, 0, A, 0, 1, 5}, '{0, P, 0, 0, 0, A, 0, 0, 5},
        '{1, E, 20'h0_2000, 0, 0, N, 0, 0, 5}};
    logic core_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, code_blank = 1'b0;
    logic self_valid = 1'b0, self_is_write = 1'b0;
    fsp_cmd_t cmd = FSP_CMD_NONE;
    logic [19:0] cmd_addr = 20'h0_0000, self_addr = 20'h0_0000, op_addr;
    logic [2:0] cmd_prot = 3'h0, nv_prot, nv_prot_wdata, active_prot;
    logic [7:0] resp_data;
    logic cmd_ready, resp_valid, resp_last, erase_go, write_go, self_go, self_refused;
    logic nv_prot_we;
    int n_errors = 0;
    int check_count = 0;
    fsp_core #(.ID_CODE(ID), .PART_NAME(NAME), .LAST_ADDR(LAST)) dut (.*,
        .fw_major(8'h01), .fw_minor(8'h02), .fw_patch(8'h03));
    fsp_nv u_nv (.core_clk, .we(nv_prot_we), .wdata(nv_prot_wdata), .bits(nv_prot));
    initial forever #50 core_clk = ~core_clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task do_reset;
        @(posedge core_clk) resetn <= 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task send(input fsp_cmd_t c, input logic [19:0] a, input logic [2:0] p, input logic b);
        @(posedge core_clk);
        {cmd, cmd_addr, cmd_prot, code_blank, cmd_valid} <= {c, a, p, b, 1'b1};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    initial begin
        #1_000_000;
        n_errors++;
        results();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].rst) do_reset();
            send(rows[i].cmd, rows[i].addr, rows[i].prot, rows[i].blank);
            chk({resp_valid, resp_data}, {1'b1, rows[i].resp}, "reply");
            chk({erase_go, write_go}, {rows[i].e, rows[i].w}, "go");
            if (rows[i].e | rows[i].w) chk(op_addr, rows[i].addr, "op_addr");
            chk(active_prot, rows[i].ap, "active_prot");
        end
        send(FSP_CMD_SIG, 20'h0_0000, 3'h0, 1'b0);
        chk(resp_data, A, "sig ack");
        for (int i = 0; i < 19; i++) begin
            repeat (2) @(posedge core_clk);
            #1;
            chk({resp_valid, resp_last, resp_data}, {1'b1, i == 18, SIG[151 - 8 * i -: 8]},
                "sig byte");
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            {self_valid, self_is_write} <= {1'b1, i[0]};
            self_addr <= (i == 0) ? 20'h0_0100 : 20'h0_2000;
            @(posedge core_clk);
            self_valid <= 1'b0;
            #1;
            chk({self_go, self_refused}, (i == 0) ? 2'b01 : 2'b10, "self");
        end
        results();
    end
endmodule
